// [orx_consts.vh]
// constants for the or/move instruction execution block
// assumes a 14-bit instruction word in the mid-range encoding
`ifndef ORX_CONSTS_VH
`define ORX_CONSTS_VH
`define ORX_OP_WIDTH 14
`define ORX_DATA_WIDTH 8
`define ORX_ADDR_WIDTH 7
`define ORX_DEST_BIT 7
`define ORX_OR_IMM_HI 6'h38
`define ORX_LOAD_IMM_HI 4'hC
`define ORX_OR_REG_HI 6'h04
`define ORX_COPY_REG_HI 6'h08
`define ORX_STORE_HI 7'h01
`define ORX_ACC_RESET 8'h00
`define ORX_ZERO_RESET 1'b0
`endif

// [orx_decode.v]
// instruction classifier for the or/move execution block
// assumes a valid instruction word presented with its strobe
`timescale 1ns/1ps
`include "orx_consts.vh"
module orx_decode (
	input wire [`ORX_OP_WIDTH-1:0] instr,
	output reg is_or_imm,
	output reg is_load_imm,
	output reg is_or_reg,
	output reg is_store,
	output reg is_copy_reg
);
	// match the opcode fields
	always @* begin
		is_or_imm = (instr[13:8] == `ORX_OR_IMM_HI);
		is_load_imm = (instr[13:10] == `ORX_LOAD_IMM_HI); // don't-care bits 9:8 ignored
		is_or_reg = (instr[13:8] == `ORX_OR_REG_HI);
		is_copy_reg = (instr[13:8] == `ORX_COPY_REG_HI);
		is_store = (instr[13:7] == `ORX_STORE_HI);
	end
endmodule

// [orx_exec.v]
// execution of or-immediate, load-immediate, or-register, store and copy-register
// assumes one instruction per cycle on instr_valid; file data arrives combinationally on file_rdata
// assumes the file register array sits outside and takes file_we, file_waddr and file_wdata
// assumes file_raddr is the one output not taken from a flop, so that the read returns in the same cycle
// What this block does
// RL1: or-immediate ors the accumulator with the literal, writes the accumulator and updates zero.
// RL2: load-immediate puts the literal in the accumulator and leaves every flag alone.
// RL3: the encoder fills the load-immediate don't-care bits with zeros, which this block does not need.
// RL4: or-register ors the accumulator with the file register, result to accumulator on d=0 or file on d=1, updates zero.
// RL5: store copies the accumulator to the addressed file register and leaves flags alone.
// RL6: copy-register moves the file register to the accumulator on d=0 or back to itself on d=1 and updates zero.
// RL7: zero is set when the 8-bit result is zero and cleared otherwise.
`timescale 1ns/1ps
`include "orx_consts.vh"
module orx_exec #(
	parameter DATA_WIDTH = `ORX_DATA_WIDTH,
	parameter ADDR_WIDTH = `ORX_ADDR_WIDTH
) (
	input wire sys_clk,
	input wire rst,
	input wire instr_valid,
	input wire [`ORX_OP_WIDTH-1:0] instr,
	output wire [ADDR_WIDTH-1:0] file_raddr,
	input wire [DATA_WIDTH-1:0] file_rdata,
	output reg file_we,
	output reg [ADDR_WIDTH-1:0] file_waddr,
	output reg [DATA_WIDTH-1:0] file_wdata,
	output reg [DATA_WIDTH-1:0] acc,
	output reg zero_flag,
	output reg zero_we
);
	// decoder outputs, at most one high at a time
	wire is_or_imm;
	wire is_load_imm;
	wire is_or_reg;
	wire is_store;
	wire is_copy_reg;
	wire [4:0] op_class;

	// instruction fields
	wire dest_file;
	wire [DATA_WIDTH-1:0] literal;

	// datapath and next state
	reg [DATA_WIDTH-1:0] operand;
	reg [DATA_WIDTH-1:0] result;
	reg next_acc_we;
	reg next_file_we;
	reg next_zero_we;
	reg [DATA_WIDTH-1:0] next_acc;
	reg next_zero;
	reg [ADDR_WIDTH-1:0] next_file_waddr;
	reg [DATA_WIDTH-1:0] next_file_wdata;

	// one-hot instruction classes, one bit per decoder output
	localparam [4:0] CLS_NONE = 5'h00;
	localparam [4:0] CLS_OR_IMM = 5'h01;
	localparam [4:0] CLS_LOAD_IMM = 5'h02;
	localparam [4:0] CLS_OR_REG = 5'h04;
	localparam [4:0] CLS_STORE = 5'h08;
	localparam [4:0] CLS_COPY_REG = 5'h10;

	// zero test of an 8-bit result
	function is_zero;
		input [DATA_WIDTH-1:0] v;
		begin
			is_zero = (v == {DATA_WIDTH{1'b0}});
		end
	endfunction

	// bitwise or of two data bytes, shared by both or forms
	function [DATA_WIDTH-1:0] or_bytes;
		input [DATA_WIDTH-1:0] a;
		input [DATA_WIDTH-1:0] b;
		begin
			or_bytes = a | b;
		end
	endfunction

	// true when the destination bit sends the result to the file
	function to_file;
		input d;
		begin
			to_file = d;
		end
	endfunction

	orx_decode u_dec (
		.instr(instr),
		.is_or_imm(is_or_imm),
		.is_load_imm(is_load_imm),
		.is_or_reg(is_or_reg),
		.is_store(is_store),
		.is_copy_reg(is_copy_reg)
	);

	assign file_raddr = instr[ADDR_WIDTH-1:0];
	assign dest_file = instr[`ORX_DEST_BIT];
	assign literal = instr[DATA_WIDTH-1:0];
	assign op_class = {is_copy_reg, is_store, is_or_reg, is_load_imm, is_or_imm};

	// second operand: literal for immediate forms, file data otherwise
	always @* begin
		operand = file_rdata;
		case (op_class)
			CLS_OR_IMM: begin
				operand = literal;
			end
			CLS_LOAD_IMM: begin
				operand = literal;
			end
			default: begin
				operand = file_rdata;
			end
		endcase
	end

	// result and write enables per instruction class
	always @* begin
		result = acc;
		next_acc_we = 1'b0;
		next_file_we = 1'b0;
		next_zero_we = 1'b0;
		if (instr_valid) begin
			case (op_class)
				CLS_OR_IMM: begin
					result = or_bytes(acc, operand); // see RL1
					next_acc_we = 1'b1;
					next_file_we = 1'b0;
					next_zero_we = 1'b1;
				end
				CLS_LOAD_IMM: begin
					result = operand; // see RL2
					next_acc_we = 1'b1;
					next_file_we = 1'b0;
					next_zero_we = 1'b0; // flags untouched
				end
				CLS_OR_REG: begin
					result = or_bytes(acc, operand); // see RL4
					next_acc_we = ~to_file(dest_file);
					next_file_we = to_file(dest_file);
					next_zero_we = 1'b1;
				end
				CLS_STORE: begin
					result = acc; // see RL5
					next_acc_we = 1'b0;
					next_file_we = 1'b1;
					next_zero_we = 1'b0; // flags untouched
				end
				CLS_COPY_REG: begin
					result = operand; // see RL6
					next_acc_we = ~to_file(dest_file);
					next_file_we = to_file(dest_file);
					next_zero_we = 1'b1; // d=1 still updates zero
				end
				CLS_NONE: begin
					result = acc; // no-op and unknown words
				end
				default: begin
					result = acc; // two classes at once cannot occur
				end
			endcase
		end
	end

	// next accumulator and zero values
	always @* begin
		next_acc = acc;
		next_zero = zero_flag;
		if (next_acc_we)
			next_acc = result;
		if (next_zero_we)
			next_zero = is_zero(result); // see RL7
	end

	// next file write port values; address follows the decoded field
	always @* begin
		next_file_waddr = file_raddr;
		next_file_wdata = result;
	end

	// accumulator
	always @(posedge sys_clk) begin
		if (rst) begin
			acc <= `ORX_ACC_RESET;
		end else begin
			acc <= next_acc;
		end
	end

	// zero flag, written only by the classes that affect it
	always @(posedge sys_clk) begin
		if (rst) begin
			zero_flag <= `ORX_ZERO_RESET;
		end else begin
			zero_flag <= next_zero;
		end
	end

	// one-cycle strobe telling the status logic zero was updated
	always @(posedge sys_clk) begin
		if (rst) begin
			zero_we <= 1'b0;
		end else begin
			zero_we <= next_zero_we;
		end
	end

	// file register write port
	always @(posedge sys_clk) begin
		if (rst) begin
			file_we <= 1'b0;
			file_waddr <= {ADDR_WIDTH{1'b0}};
			file_wdata <= {DATA_WIDTH{1'b0}};
		end else begin
			file_we <= next_file_we;
			file_waddr <= next_file_waddr;
			file_wdata <= next_file_wdata;
		end
	end
endmodule

// [orx_monitor.sv]
// assertions on the or/move execution block ports
// bound to orx_exec; one clock, sync reset
`timescale 1ns/1ps
module orx_monitor (
	input wire sys_clk,
	input wire rst,
	input wire instr_valid,
	input wire [13:0] instr,
	input wire [7:0] file_rdata,
	input wire file_we,
	input wire [7:0] file_wdata,
	input wire [7:0] acc,
	input wire zero_flag,
	input wire zero_we
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// upper opcode bits of a taken word
	wire [5:0] op = instr_valid ? instr[13:8] : 6'h3F;
	// one property per instruction kind
	property p_ori; logic [7:0] r;
	(op == 6'h38, r = acc | instr[7:0]) |=> acc == r && zero_flag == (r == 0) && zero_we; endproperty
	property p_ldi; logic [7:0] k;
	(op[5:2] == 4'hC, k = instr[7:0]) |=> acc == k && !zero_we && $stable(zero_flag); endproperty
	property p_orr; logic [7:0] r; logic d; (op == 6'h04, r = acc | file_rdata, d = instr[7]) |=>
	zero_flag == (r == 0) && (d ? file_we && file_wdata == r : acc == r && !file_we); endproperty
	property p_st; logic [7:0] a;
	(op == 6'h00 && instr[7], a = acc) |=> file_we && file_wdata == a && !zero_we; endproperty
	property p_cpy; logic [7:0] f; logic d; (op == 6'h08, f = file_rdata, d = instr[7]) |=>
	zero_we && zero_flag == (f == 0) && (d ? file_wdata == f : acc == f); endproperty
	property p_idle; !instr_valid |=> !file_we && !zero_we; endproperty
	a_ori: assert property (p_ori) else $error("ori");
	a_ldi: assert property (p_ldi) else $error("ldi");
	a_orr: assert property (p_orr) else $error("orr");
	a_st: assert property (p_st) else $error("st");
	a_cpy: assert property (p_cpy) else $error("cpy");
	a_idle: assert property (p_idle) else $error("idle");
endmodule
bind orx_exec orx_monitor u_mon (.*);

// [tb_orx_exec.sv]
// bench for the or/move execution block
// bench holds the file read data; one op at a time
`timescale 1ns/1ps
module tb_orx_exec;
	reg sys_clk = 0, rst = 1, instr_valid = 0;
	reg [13:0] instr = 0;
	reg [7:0] file_rdata = 0;
	wire [6:0] file_raddr, file_waddr;
	wire [7:0] file_wdata, acc;
	wire file_we, zero_flag, zero_we;
	wire [7:0] fl = {5'h00, zero_flag, zero_we, file_we};
	integer fails = 0, n_checks = 0;
	always #5 sys_clk = ~sys_clk;
	orx_exec u_dut (.*);
	// one value comparison
	task chk(input [31:0] nm, input [7:0] e, input [7:0] g); begin
		n_checks = n_checks + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	end endtask
	// one instruction held for one cycle
	task op(input [13:0] i, input [7:0] d); begin
		@(posedge sys_clk) #1;
		instr_valid = 1;
		instr = i;
		file_rdata = d;
		@(posedge sys_clk) #1;
		instr_valid = 0;
	end endtask
	task test_imm; begin
		op(14'h3800, 8'h00);
		chk("ori0", 8'h06, fl);
		op(14'h305A, 8'h00);
		chk("ldi", 8'h5A, acc);
		chk("ldif", 8'h04, fl);
		op(14'h3881, 8'h00);
		chk("ori", 8'hDB, acc);
		chk("orif", 8'h02, fl);
		$display("test imm done");
	end endtask
	task test_reg; begin
		op(14'h0485, 8'h24);
		chk("orw", 8'hFF, file_wdata);
		chk("orwf", 8'h03, fl);
		op(14'h00FF, 8'h00);
		chk("st", 8'hDB, file_wdata);
		chk("sta", 8'h7F, {1'b0, file_waddr});
		chk("stf", 8'h01, fl);
		chk("ra", 8'h7F, {1'b0, file_raddr});
		op(14'h0800, 8'h00);
		chk("cpa", 8'h06, fl);
		op(14'h0880, 8'h3C);
		chk("cpf", 8'h03, fl);
		chk("cpw", 8'h00, acc);
		op(14'h3001, 8'h00);
		op(14'h3FFF, 8'h00);
		chk("unk", 8'h01, acc);
		chk("unkf", 8'h00, fl);
		$display("test reg done");
	end endtask
	task complete_run; begin
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	end endtask
	// main sequence after ten reset cycles
	initial begin
		repeat (10) @(posedge sys_clk);
		#1 rst = 0;
		test_imm;
		test_reg;
		complete_run;
	end
	// watchdog
	initial begin
		#5000;
		fails = fails + 1;
		complete_run;
	end
endmodule
